// File: rtl/skcd_pkg.sv
// Shared constants for the station keypad command decoder
package skcd_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    // Key bit positions
    localparam int unsigned NKEYS = 6;
    localparam int unsigned K_SETUP = 0;
    localparam int unsigned K_CLAMP = 1;
    localparam int unsigned K_STROKE = 2;
    localparam int unsigned K_RAISE = 3;
    localparam int unsigned K_ILEFT = 4;
    localparam int unsigned K_IRIGHT = 5;
    // Times in milliseconds
    localparam int unsigned HOLD_MS = 3000;
    localparam int unsigned DEB_MS = 10;
    localparam int unsigned WIN_MS = 40;
    // Derived cycle counts (least times, exact multiples here)
    localparam int unsigned HOLD_CYC = HOLD_MS * CYC_PER_MS;
    localparam int unsigned DEB_CYC = DEB_MS * CYC_PER_MS;
    localparam int unsigned WIN_CYC = WIN_MS * CYC_PER_MS;
    // Reset values
    localparam logic RST_SETUP = 1'b0;
    localparam logic RST_CLAMP = 1'b0;
    localparam logic RST_HALF = 1'b0;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_COLLECT,
        ST_HOLD,
        ST_RELEASE
    } skcd_state_t;
endpackage

// File: rtl/skcd_debounce.sv
// Key synchroniser and debouncer for the keypad
`timescale 1ns/1ps
module skcd_debounce #(
    parameter int unsigned N = 6,
    parameter int unsigned DEB_CYC = 250000
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [N-1:0] key_raw_i,
    output logic [N-1:0] key_db_o
);
    localparam int unsigned CW = $clog2(DEB_CYC + 1);
    localparam logic [CW-1:0] DEB_LAST = CW'(DEB_CYC - 1);

    // Refused at elaboration: a one-cycle interval would not filter anything
    if (DEB_CYC < 2 || N < 1) begin : g_bad_param
        $error("skcd_debounce: bad parameters");
    end

    logic [N-1:0] sync1_q;
    logic [N-1:0] sync2_q;
    logic [N-1:0] stable_q;
    logic [CW-1:0] cnt_q [N];
    logic [N-1:0] differ;
    logic [N-1:0] settled;

    assign differ = sync2_q ^ stable_q;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= key_raw_i;
            sync2_q <= sync1_q;
        end
    end

    // Accept a new level only after it held unchanged for the whole interval
    for (genvar g = 0; g < N; g++) begin : g_key
        assign settled[g] = differ[g] && (cnt_q[g] == DEB_LAST);
        always_ff @(posedge mclk_i) begin
            if (!rst_n_i) begin
                cnt_q[g] <= '0;
                stable_q[g] <= 1'b0;
            end else if (!differ[g] || settled[g]) begin
                cnt_q[g] <= '0;
                stable_q[g] <= settled[g] ? sync2_q[g] : stable_q[g];
            end else begin
                cnt_q[g] <= cnt_q[g] + CW'(1);
            end
        end
        deb_settle_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
            (stable_q[g] != $past(stable_q[g])) |-> $past(cnt_q[g]) == DEB_LAST)
            else $error("debounced key changed before interval elapsed");
    end

    assign key_db_o = stable_q;
endmodule

// File: rtl/skcd_decoder.sv
// Station keypad command decoder, top level
`timescale 1ns/1ps
module skcd_decoder #(
    parameter int unsigned HOLD_CYC = skcd_pkg::HOLD_CYC,
    parameter int unsigned DEB_CYC = skcd_pkg::DEB_CYC,
    parameter int unsigned WIN_CYC = skcd_pkg::WIN_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic setup_mode_key_i,
    input wire logic clamp_key_i,
    input wire logic stroke_key_i,
    input wire logic raise_key_i,
    input wire logic index_left_key_i,
    input wire logic index_right_key_i,
    input wire logic setup_exit_i,
    input wire logic carriage_front_i,
    input wire logic stations_raised_i,
    output logic setup_mode_o,
    output logic clamp_locked_o,
    output logic half_index_o,
    output logic stroke_fwd_o,
    output logic stroke_back_o,
    output logic stations_lower_o,
    output logic stations_raise_o,
    output logic print_cycle_o,
    output logic index_left_o,
    output logic index_right_o,
    output logic half_enter_o,
    output logic half_return_o
);
    localparam int unsigned NK = skcd_pkg::NKEYS;
    localparam int unsigned TW = $clog2(HOLD_CYC + 1);
    localparam logic [TW-1:0] WIN_LAST = TW'(WIN_CYC - 1);
    localparam logic [TW-1:0] HOLD_LAST = TW'(HOLD_CYC - 1);
    localparam int unsigned NC = 9;

    // Refused at elaboration: the hold timer must outlast the window
    if (WIN_CYC < 2 || HOLD_CYC <= WIN_CYC || DEB_CYC < 2) begin : g_bad_param
        $error("skcd_decoder: timing parameters out of range");
    end

    function automatic logic [NK-1:0] key_set(input int unsigned a, input int unsigned b);
        logic [NK-1:0] m;
        m = '0;
        m[a] = 1'b1;
        m[b] = 1'b1;
        return m;
    endfunction

    logic [NK-1:0] keys_raw;
    logic [NK-1:0] keys_db;
    skcd_pkg::skcd_state_t state_q, state_d;
    logic [TW-1:0] tmr_q, tmr_d;
    logic [NK-1:0] seen_q, seen_d;
    logic setup_q, setup_d;
    logic clamp_q, clamp_d;
    logic half_q, half_d;
    logic [NC-1:0] cmd_q, cmd_d;

    assign keys_raw = {index_right_key_i, index_left_key_i, raise_key_i, stroke_key_i, clamp_key_i, setup_mode_key_i};

    skcd_debounce #(
        .N(NK),
        .DEB_CYC(DEB_CYC)
    ) u_deb (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .key_raw_i(keys_raw),
        .key_db_o(keys_db)
    );

    // Pressed set: every key seen during the window, exact match only
    wire [NK-1:0] pressed = seen_q | keys_db;
    wire win_end = (state_q == skcd_pkg::ST_COLLECT) && (tmr_q == WIN_LAST);
    wire decide = win_end && setup_q;
    wire is_setup = pressed == key_set(skcd_pkg::K_SETUP, skcd_pkg::K_SETUP);
    wire is_clamp = pressed == key_set(skcd_pkg::K_CLAMP, skcd_pkg::K_CLAMP);
    wire is_stroke = pressed == key_set(skcd_pkg::K_STROKE, skcd_pkg::K_STROKE);
    wire is_raise = pressed == key_set(skcd_pkg::K_RAISE, skcd_pkg::K_RAISE);
    wire is_cycle = pressed == key_set(skcd_pkg::K_SETUP, skcd_pkg::K_STROKE);
    wire is_ileft = pressed == key_set(skcd_pkg::K_SETUP, skcd_pkg::K_ILEFT);
    wire is_iright = pressed == key_set(skcd_pkg::K_SETUP, skcd_pkg::K_IRIGHT);
    wire is_half = pressed == key_set(skcd_pkg::K_ILEFT, skcd_pkg::K_IRIGHT);
    wire do_clamp = decide && is_clamp;
    wire do_half = decide && is_half;
    wire hold_done = (state_q == skcd_pkg::ST_HOLD) && keys_db[skcd_pkg::K_SETUP] && (tmr_q == HOLD_LAST);
    wire any_cmd = |cmd_q;

    // Command pulse order: fwd, back, lower, raise, cycle, left, right, half in, half out
    always_comb begin
        cmd_d = '0;
        cmd_d[0] = decide && is_stroke && !carriage_front_i;
        cmd_d[1] = decide && is_stroke && carriage_front_i;
        cmd_d[2] = decide && is_raise && stations_raised_i;
        cmd_d[3] = decide && is_raise && !stations_raised_i;
        cmd_d[4] = decide && is_cycle;
        cmd_d[5] = decide && is_ileft;
        cmd_d[6] = decide && is_iright;
        cmd_d[7] = do_half && !half_q;
        cmd_d[8] = do_half && half_q;
    end

    // Setup entry wins over an exit request in the same cycle
    assign setup_d = hold_done ? 1'b1 : (setup_exit_i ? 1'b0 : setup_q);
    assign clamp_d = do_clamp ? !clamp_q : clamp_q;
    assign half_d = do_half ? !half_q : half_q;

    always_comb begin
        state_d = state_q;
        tmr_d = tmr_q;
        seen_d = seen_q;
        case (state_q)
            skcd_pkg::ST_IDLE: begin
                tmr_d = '0;
                seen_d = '0;
                if (|keys_db) begin
                    state_d = skcd_pkg::ST_COLLECT;
                    seen_d = keys_db;
                end
            end
            skcd_pkg::ST_COLLECT: begin
                tmr_d = tmr_q + TW'(1);
                seen_d = pressed;
                if (win_end) begin
                    // Timer keeps running so the hold counts from first press
                    state_d = is_setup ? skcd_pkg::ST_HOLD : skcd_pkg::ST_RELEASE;
                end
            end
            skcd_pkg::ST_HOLD: begin
                tmr_d = tmr_q + TW'(1);
                if (!keys_db[skcd_pkg::K_SETUP] || hold_done) begin
                    state_d = skcd_pkg::ST_RELEASE;
                end
            end
            skcd_pkg::ST_RELEASE: begin
                // Nothing more happens until every key is up
                if (keys_db == '0) begin
                    state_d = skcd_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = skcd_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_q <= skcd_pkg::ST_IDLE;
            tmr_q <= '0;
            seen_q <= '0;
            cmd_q <= '0;
        end else begin
            state_q <= state_d;
            tmr_q <= tmr_d;
            seen_q <= seen_d;
            cmd_q <= cmd_d;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            setup_q <= skcd_pkg::RST_SETUP;
            clamp_q <= skcd_pkg::RST_CLAMP;
            half_q <= skcd_pkg::RST_HALF;
        end else begin
            setup_q <= setup_d;
            clamp_q <= clamp_d;
            half_q <= half_d;
        end
    end

    assign setup_mode_o = setup_q;
    assign clamp_locked_o = clamp_q;
    assign half_index_o = half_q;
    assign stroke_fwd_o = cmd_q[0];
    assign stroke_back_o = cmd_q[1];
    assign stations_lower_o = cmd_q[2];
    assign stations_raise_o = cmd_q[3];
    assign print_cycle_o = cmd_q[4];
    assign index_left_o = cmd_q[5];
    assign index_right_o = cmd_q[6];
    assign half_enter_o = cmd_q[7];
    assign half_return_o = cmd_q[8];

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    setup_gate_a: assert property ((any_cmd || clamp_q != $past(clamp_q)) |-> $past(setup_q))
        else $error("command issued outside setup mode");
    hold_time_a: assert property ($rose(setup_q) |-> $past(tmr_q) == HOLD_LAST && $past(keys_db[0]))
        else $error("setup mode entered without full hold");
    clamp_toggle_a: assert property ($past(do_clamp) |-> clamp_q != $past(clamp_q, 2))
        else $error("clamp did not toggle on press");
    stroke_dir_a: assert property (stroke_back_o |-> $past(carriage_front_i) && !stroke_fwd_o)
        else $error("stroke direction wrong");
    height_dir_a: assert property (stations_lower_o |-> $past(stations_raised_i) && !stations_raise_o)
        else $error("raise/lower direction wrong");
    cycle_combo_a: assert property (print_cycle_o |-> $past(pressed) == 6'h05 && $past(win_end))
        else $error("print cycle without setup and stroke pair");
    index_pair_a: assert property ((index_left_o || index_right_o) |-> $past(pressed[0]))
        else $error("index without setup key");
    half_enter_a: assert property (half_enter_o |-> half_q && !$past(half_q))
        else $error("half-index entry mismatch");
    half_return_a: assert property (half_return_o |-> !half_q && $past(half_q))
        else $error("half-index return mismatch");
    once_press_a: assert property (any_cmd |-> state_q == skcd_pkg::ST_RELEASE ##1 !any_cmd)
        else $error("more than one action per press");

    cycle_c: cover property (print_cycle_o);
    setup_c: cover property ($rose(setup_q));
    half_round_c: cover property (half_enter_o ##[1:1000] half_return_o);
endmodule

// File: verif/skcd_operator.sv
// Operator model pressing keys on one station keypad
`timescale 1ns/1ps
module skcd_operator (
    input wire logic mclk_i,
    output logic [5:0] keys_o
);
    initial keys_o = 6'h00;
    // Press a, add b after gap, hold, release; chat bounces a first
    task automatic press(input logic [5:0] a, input logic [5:0] b, input int gap, input int hold,
                         input int chat);
        for (int i = 0; i < chat; i++) begin
            @(negedge mclk_i);
            keys_o = (i % 2 == 0) ? a : 6'h00;
        end
        @(negedge mclk_i);
        if (gap > 0) begin
            keys_o = a;
            repeat (gap) @(negedge mclk_i);
        end
        keys_o = a | b;
        repeat (hold) @(negedge mclk_i);
        // Long idle so the debouncer sees all keys released
        keys_o = 6'h00;
        repeat (40) @(negedge mclk_i);
    endtask
endmodule

// File: verif/tb_top.sv
// Self-checking bench for the keypad command decoder
`timescale 1ns/1ps
module tb_top;
    localparam logic [5:0] KS = 6'h01;
    localparam logic [5:0] KC = 6'h02;
    localparam logic [5:0] KT = 6'h04;
    localparam logic [5:0] KR = 6'h08;
    localparam logic [5:0] KL = 6'h10;
    localparam logic [5:0] KI = 6'h20;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic setup_exit_i = 1'b0;
    logic carriage_front_i = 1'b0;
    logic stations_raised_i = 1'b0;
    logic setup_mode_o, clamp_locked_o, half_index_o;
    wire [5:0] keys;
    wire [8:0] pv;
    int cnt [9];
    int n_mismatch = 0;
    int checks_done = 0;

    always #20 mclk_i = ~mclk_i;

    skcd_operator op_u (.mclk_i(mclk_i), .keys_o(keys));

    skcd_decoder #(.HOLD_CYC(400), .DEB_CYC(4), .WIN_CYC(20)) dut_u (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .setup_mode_key_i(keys[skcd_pkg::K_SETUP]), .clamp_key_i(keys[skcd_pkg::K_CLAMP]),
        .stroke_key_i(keys[skcd_pkg::K_STROKE]), .raise_key_i(keys[skcd_pkg::K_RAISE]),
        .index_left_key_i(keys[skcd_pkg::K_ILEFT]), .index_right_key_i(keys[skcd_pkg::K_IRIGHT]),
        .setup_exit_i(setup_exit_i), .carriage_front_i(carriage_front_i),
        .stations_raised_i(stations_raised_i), .setup_mode_o(setup_mode_o),
        .clamp_locked_o(clamp_locked_o), .half_index_o(half_index_o),
        .stroke_fwd_o(pv[8]), .stroke_back_o(pv[7]), .stations_lower_o(pv[6]),
        .stations_raise_o(pv[5]), .print_cycle_o(pv[4]), .index_left_o(pv[3]),
        .index_right_o(pv[2]), .half_enter_o(pv[1]), .half_return_o(pv[0]));

    // Counting pulses avoids tying checks to exact decision latency
    always @(posedge mclk_i) begin
        for (int i = 0; i < 9; i++) begin
            if (pv[i] !== 1'b0) cnt[i] <= cnt[i] + 1;
        end
    end

    task automatic check_lvl(input string name, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic check_pulses(input logic [8:0] exp);
        logic [8:0] got;
        logic dup;
        dup = 1'b0;
        for (int i = 0; i < 9; i++) begin
            got[i] = (cnt[i] != 0);
            if (cnt[i] > 1) dup = 1'b1;
        end
        checks_done++;
        if (got !== exp || dup) begin
            n_mismatch++;
            $display("CHECK FAILED pulses expected %h seen %h repeated %b", exp, got, dup);
        end
    endtask

    task automatic ep(input logic [5:0] a, input logic [5:0] b, input int gap, input int hold,
                      input int chat);
        for (int i = 0; i < 9; i++) cnt[i] = 0;
        op_u.press(a, b, gap, hold, chat);
    endtask

    task automatic s_locked();
        ep(KC, 6'h00, 0, 40, 0);
        check_lvl("clamp", 1'b0, clamp_locked_o);
        ep(KT, 6'h00, 0, 40, 0);
        check_pulses(9'h000);
        ep(KL, KI, 0, 40, 0);
        check_pulses(9'h000);
    endtask

    task automatic s_entry();
        ep(KS, 6'h00, 0, 200, 0);
        check_lvl("setup short", 1'b0, setup_mode_o);
        ep(KS, 6'h00, 0, 450, 0);
        check_lvl("setup long", 1'b1, setup_mode_o);
    endtask

    task automatic s_clamp();
        ep(KC, 6'h00, 0, 40, 0);
        check_lvl("clamp on", 1'b1, clamp_locked_o);
        ep(KC, 6'h00, 0, 40, 0);
        check_lvl("clamp off", 1'b0, clamp_locked_o);
    endtask

    task automatic s_motion();
        carriage_front_i = 1'b1;
        ep(KT, 6'h00, 0, 40, 0);
        check_pulses(9'h080);
        carriage_front_i = 1'b0;
        ep(KT, 6'h00, 0, 40, 0);
        check_pulses(9'h100);
        stations_raised_i = 1'b1;
        ep(KR, 6'h00, 0, 40, 0);
        check_pulses(9'h040);
        stations_raised_i = 1'b0;
        ep(KR, 6'h00, 0, 40, 0);
        check_pulses(9'h020);
    endtask

    task automatic s_combo();
        ep(KS, KT, 5, 40, 0);
        check_pulses(9'h010);
        ep(KS, KL, 5, 40, 0);
        check_pulses(9'h008);
        ep(KL, KS, 5, 40, 0);
        check_pulses(9'h008);
        ep(KS, KI, 5, 40, 0);
        check_pulses(9'h004);
        ep(KS | KL, KI, 0, 40, 0);
        check_pulses(9'h000);
    endtask

    task automatic s_half();
        ep(KL, KI, 3, 40, 0);
        check_pulses(9'h002);
        check_lvl("half on", 1'b1, half_index_o);
        ep(KI, KL, 0, 40, 0);
        check_pulses(9'h001);
        check_lvl("half off", 1'b0, half_index_o);
    endtask

    task automatic s_bounce();
        ep(KT, 6'h00, 0, 40, 3);
        check_pulses(9'h100);
        ep(KT, 6'h00, 0, 2, 0);
        check_pulses(9'h000);
    endtask

    // Clamp is locked first so that an ignored press after exit is visible
    task automatic s_exit();
        ep(KC, 6'h00, 0, 40, 0);
        check_lvl("clamp before exit", 1'b1, clamp_locked_o);
        setup_exit_i = 1'b1;
        @(negedge mclk_i);
        setup_exit_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        check_lvl("setup exit", 1'b0, setup_mode_o);
        ep(KC, 6'h00, 0, 40, 0);
        check_lvl("clamp after exit", 1'b1, clamp_locked_o);
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (16) @(negedge mclk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        s_locked();
        s_entry();
        s_clamp();
        s_motion();
        s_combo();
        s_half();
        s_bounce();
        s_exit();
        tally_and_finish();
    end

    // About 2400 cycles expected; generous margin before giving up
    initial begin
        repeat (20000) @(posedge mclk_i);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
